// *** precharge_pkg.sv ***
// Shared constants and types for the bus precharge select block.
// Assumes a single 40 MHz core clock on both ends.
package precharge_pkg;

	localparam int unsigned CLK_PERIOD_PS      = 25000;
	// Standard precharge is about half a cycle: driven in the high half of the cycle, cut at the falling edge.
	localparam int unsigned STD_PRECHARGE_PS   = 12500;
	localparam int unsigned EXT_PRECHARGE_PS   = 25000;
	localparam int unsigned EXT_PRECHARGE_CYC  =
		(EXT_PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned NUM_LINES          = 3;
	localparam int unsigned LINE_ADDR_BUSY     = 0;
	localparam int unsigned LINE_DATA_BUSY     = 1;
	localparam int unsigned LINE_RETRY         = 2;
	localparam logic        MODE_STANDARD      = 1'b1;
	localparam logic        MODE_EXTENDED      = 1'b0;

	typedef enum logic [1:0] {
		LN_IDLE,
		LN_DRIVE_LOW,
		LN_PRECHARGE
	} line_state_t;

	typedef enum logic [1:0] {
		Q_RUN,
		Q_REQUEST,
		Q_QUIESCENT
	} quiesce_state_t;

endpackage

// *** precharge_if.sv ***
// Interface joining the device end and the system end of the shared lines.
// Assumes the testbench resolves the open lines from the enables.
`timescale 1ns/10ps
`default_nettype none
interface precharge_if;
	import precharge_pkg::*;
	logic [NUM_LINES-1:0] line_out;
	logic [NUM_LINES-1:0] line_oe;
	logic [NUM_LINES-1:0] line_in;
	logic                 quiesce_request;
	logic                 quiesce_acknowledge;
	logic                 hard_reset_in_n;

	modport device (
		output line_out,
		output line_oe,
		input  line_in,
		output quiesce_request,
		input  quiesce_acknowledge,
		input  hard_reset_in_n
	);
	modport system (
		input  line_out,
		input  line_oe,
		input  line_in,
		input  quiesce_request,
		output quiesce_acknowledge,
		output hard_reset_in_n
	);
endinterface
`default_nettype wire

// *** precharge_device.sv ***
// Device end: drives the three busy and retry lines with precharge before release.
// Assumes hard_reset_in_n and quiesce_acknowledge are synchronous to core_clk_i.
//
// Behaviour
// RULE_01: Precharge lines high before releasing them.
// RULE_02: Standard mode precharges about half a cycle.
// RULE_03: Extended mode precharges one full cycle.
// RULE_04: Acknowledge high at reset release: standard.
// RULE_05: Acknowledge low at reset release: extended.
// RULE_06: System should default to standard precharge.
// RULE_07: System can assert acknowledge after reset.
// RULE_08: Request answered by acknowledge before quiescence.
// RULE_09: Acknowledge may equal inverted hard reset.
// RULE_10: Hard reset low active, sampled rising.
// RULE_11: Selection held until next hard reset.
`timescale 1ns/10ps
`default_nettype none
module precharge_device
	import precharge_pkg::*;
#(
	parameter int unsigned EXT_CYCLES = EXT_PRECHARGE_CYC
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	precharge_if.device               bus,
	input  wire logic [NUM_LINES-1:0] assert_req_i,
	input  wire logic                 stop_req_i,
	output logic                      extended_mode_o,
	output logic                      quiescent_o
);

	// The down counter is eight bits wide, so longer precharge cannot be served.
	if (EXT_CYCLES < 1 || EXT_CYCLES > 255) begin : g_bad_ext_cycles
		$error("EXT_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers shared by the line machine and the half cycle cut.

	function automatic logic is_standard(input logic mode_std);
		return mode_std == MODE_STANDARD;
	endfunction

	function automatic logic precharge_done(input logic mode_std, input logic [7:0] count);
		return is_standard(mode_std) || (count == 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Mode strap. Caught by a clocked process at the hard reset rising edge,
	// never by the asynchronous reset itself.

	logic hard_reset_in_n_q_r;
	logic mode_std_r;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hard_reset_in_n_q_r <= 1'b0;
		end else begin
			hard_reset_in_n_q_r <= bus.hard_reset_in_n;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_std_r <= MODE_STANDARD;
		end else if (bus.hard_reset_in_n && !hard_reset_in_n_q_r) begin // RULE_10
			// High selects standard, low selects extended.
			mode_std_r <= bus.quiesce_acknowledge; // RULE_04 RULE_05
		end
	end // RULE_11

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			extended_mode_o <= 1'b0;
		end else begin
			extended_mode_o <= (mode_std_r == MODE_EXTENDED);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Line drivers. The standard half cycle is cut by one falling-edge flop on
	// the enable; extended mode counts whole cycles on the rising edge instead.

	line_state_t      st_r   [NUM_LINES];
	logic       [7:0] cnt_r  [NUM_LINES];
	logic [NUM_LINES-1:0] out_r;
	logic [NUM_LINES-1:0] oe_r;
	logic [NUM_LINES-1:0] half_cut_r;
	logic [NUM_LINES-1:0] want_low;

	// Hard reset blocks new assertions and ends a low drive through the usual
	// precharge, so a line is never floated straight from low.
	assign want_low = assert_req_i & {NUM_LINES{bus.hard_reset_in_n}};

	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				st_r[g] <= LN_IDLE;
			end else begin
				case (st_r[g])
					LN_IDLE: begin
						if (want_low[g]) begin
							st_r[g] <= LN_DRIVE_LOW;
						end
					end
					LN_DRIVE_LOW: begin
						if (!want_low[g]) begin
							st_r[g] <= LN_PRECHARGE; // RULE_01
						end
					end
					default: begin
						if (precharge_done(mode_std_r, cnt_r[g])) begin
							st_r[g] <= LN_IDLE; // RULE_03
						end
					end
				endcase
			end
		end

		// Extended precharge length, loaded as the low drive ends.
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cnt_r[g] <= 8'h00;
			end else if (st_r[g] == LN_DRIVE_LOW && !want_low[g]) begin
				cnt_r[g] <= 8'(EXT_CYCLES - 1);
			end else if (st_r[g] == LN_PRECHARGE && cnt_r[g] != 8'h00) begin
				cnt_r[g] <= cnt_r[g] - 8'h01;
			end
		end

		// Level is low only while asserted, so the precharge starts at release.
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				out_r[g] <= 1'b1;
			end else begin
				out_r[g] <= !(want_low[g] && st_r[g] != LN_PRECHARGE); // RULE_01
			end
		end

		// Enable rises with the low drive and falls once the precharge is done.
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				oe_r[g] <= 1'b0;
			end else if (st_r[g] == LN_IDLE) begin
				oe_r[g] <= want_low[g];
			end else if (st_r[g] == LN_PRECHARGE && precharge_done(mode_std_r, cnt_r[g])) begin
				oe_r[g] <= 1'b0; // RULE_03
			end
		end

		// Cuts the standard precharge drive at mid cycle.
		always_ff @(negedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				half_cut_r[g] <= 1'b0;
			end else begin
				half_cut_r[g] <= (st_r[g] == LN_PRECHARGE) && is_standard(mode_std_r); // RULE_02
			end
		end
	end

	assign bus.line_out = out_r;
	assign bus.line_oe  = oe_r & ~half_cut_r;

	////////////////////////////////////////////////////////////////////////
	// Soft stop handshake. The state is only reported quiescent once the
	// acknowledge answers the request.

	quiesce_state_t q_st_r;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_st_r      <= Q_RUN;
			quiescent_o <= 1'b0;
		end else if (!bus.hard_reset_in_n) begin
			q_st_r      <= Q_RUN;
			quiescent_o <= 1'b0;
		end else begin
			case (q_st_r)
				Q_RUN: begin
					if (stop_req_i) begin
						q_st_r <= Q_REQUEST;
					end
				end
				Q_REQUEST: begin
					if (!stop_req_i) begin
						q_st_r <= Q_RUN;
					end else if (bus.quiesce_acknowledge) begin
						q_st_r      <= Q_QUIESCENT; // RULE_08
						quiescent_o <= 1'b1;
					end
				end
				default: begin
					if (!stop_req_i) begin
						q_st_r      <= Q_RUN;
						quiescent_o <= 1'b0;
					end
				end
			endcase
		end
	end

	logic quiesce_request_r;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quiesce_request_r <= 1'b0;
		end else begin
			quiesce_request_r <= bus.hard_reset_in_n && stop_req_i;
		end
	end
	assign bus.quiesce_request = quiesce_request_r;

endmodule
`default_nettype wire

// *** precharge_system.sv ***
// System end: drives hard reset and quiesce acknowledge toward the device.
// Assumes the mode strap is held at the hard reset release.
`timescale 1ns/10ps
`default_nettype none
module precharge_system
	import precharge_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	precharge_if.system bus,
	input  wire logic hard_reset_req_i,
	input  wire logic extended_sel_i,
	output logic      request_seen_o
);

	logic hard_reset_in_n_r;
	logic quiesce_acknowledge_r;

	////////////////////////////////////////////////////////////////////////
	// Reset drive, active low; released one cycle after hard_reset_req_i drops.

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hard_reset_in_n_r <= 1'b0;
		end else begin
			hard_reset_in_n_r <= !hard_reset_req_i; // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strap while in reset, then free to answer requests afterwards.

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quiesce_acknowledge_r <= 1'b1;
		end else if (!hard_reset_in_n_r || hard_reset_req_i) begin
			// Standard is the default unless extended is asked for.
			quiesce_acknowledge_r <= !extended_sel_i; // RULE_06
		end else begin
			quiesce_acknowledge_r <= bus.quiesce_request; // RULE_07 RULE_08
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			request_seen_o <= 1'b0;
		end else begin
			request_seen_o <= bus.quiesce_request;
		end
	end

	assign bus.hard_reset_in_n     = hard_reset_in_n_r;
	assign bus.quiesce_acknowledge = quiesce_acknowledge_r; // RULE_09

endmodule
`default_nettype wire

// *** precharge_select_checker.sv ***
// Concurrent checks on the link between the device end and the system end.
// Assumes one core clock and that it sits beside the interface instance.
`timescale 1ns/10ps
`default_nettype none
module precharge_select_checker
	import precharge_pkg::*;
(
	input wire logic                 core_clk_i,
	input wire logic                 rst_n_i,
	input wire logic [NUM_LINES-1:0] line_out,
	input wire logic [NUM_LINES-1:0] line_oe,
	input wire logic                 quiesce_request,
	input wire logic                 quiesce_acknowledge,
	input wire logic                 hard_reset_in_n,
	input wire logic [NUM_LINES-1:0] assert_req_i,
	input wire logic                 stop_req_i,
	input wire logic                 extended_mode_o,
	input wire logic                 quiescent_o
);
	default clocking dclk @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [NUM_LINES-1:0] low_w = line_oe & ~line_out;
	////////////////////////////////////////////////////////////////////////////////
	drive_low_a: assert property (hard_reset_in_n ##1 hard_reset_in_n |->
		low_w == $past(assert_req_i)) else $error("Line drive does not follow request.");
	// The standard precharge lies between rising edges, so this one looks at falling edges.
	no_float_a: assert property (@(negedge core_clk_i) hard_reset_in_n |->
		($past(low_w) & ~line_oe) == '0) else $error("Line released while low.");
	released_high_a: assert property ((line_out | line_oe) == '1)
		else $error("Released line not parked high.");
	// The half cycle cut lands between edges, so only the upper bound is seen here.
	precharge_end_a: assert property (hard_reset_in_n ##1 hard_reset_in_n |->
		($past(line_oe & line_out & ~assert_req_i) & line_oe) == '0)
		else $error("Precharge lasts too long.");
	mode_sample_a: assert property ($rose(hard_reset_in_n) |=> ##1
		extended_mode_o == !$past(quiesce_acknowledge, 2)) else $error("Wrong mode sampled.");
	mode_hold_a: assert property (hard_reset_in_n && $past(hard_reset_in_n) &&
		$past(hard_reset_in_n, 2) && $past(hard_reset_in_n, 3) |-> $stable(extended_mode_o))
		else $error("Mode changed.");
	request_rise_a: assert property ((stop_req_i && hard_reset_in_n) ##1
		hard_reset_in_n |-> quiesce_request) else $error("Request not raised.");
	ack_answer_a: assert property ((quiesce_request && hard_reset_in_n) ##1
		hard_reset_in_n |-> quiesce_acknowledge) else $error("Request not acknowledged.");
	quiet_cause_a: assert property ($rose(quiescent_o) |->
		$past(quiesce_request && quiesce_acknowledge)) else $error("Quiescent too early.");
	////////////////////////////////////////////////////////////////////////////////
	cover property ($rose(hard_reset_in_n) ##2 extended_mode_o);
	cover property (|low_w);
	cover property ($rose(quiescent_o));
endmodule
`default_nettype wire

// *** test_bus_precharge_select.sv ***
// Self-checking bench joining both ends of the precharge select link.
// Assumes a 40 MHz clock; open lines resolve high when nobody drives them.
`timescale 1ns/10ps
`default_nettype none
module test_bus_precharge_select;
	import precharge_pkg::*;
	logic                 core_clk_i;
	logic                 rst_n_i;
	logic [NUM_LINES-1:0] assert_req_i;
	logic                 stop_req_i;
	logic                 hard_reset_req_i;
	logic                 extended_sel_i;
	wire logic            extended_mode_o;
	wire logic            quiescent_o;
	wire logic            request_seen_o;
	int                   num_errors;
	int                   samples_checked;
	int                   seed;
	int                   ext_m;
	int                   ln;
	int                   mode_q[$];
	precharge_if bus_if ();
	assign bus_if.line_in = bus_if.line_out | ~bus_if.line_oe;
	precharge_device precharge_device_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.bus(bus_if.device), .assert_req_i(assert_req_i), .stop_req_i(stop_req_i),
		.extended_mode_o(extended_mode_o), .quiescent_o(quiescent_o));
	precharge_system precharge_system_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.bus(bus_if.system), .hard_reset_req_i(hard_reset_req_i),
		.extended_sel_i(extended_sel_i), .request_seen_o(request_seen_o));
	precharge_select_checker precharge_select_checker_inst (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .line_out(bus_if.line_out), .line_oe(bus_if.line_oe),
		.quiesce_request(bus_if.quiesce_request), .hard_reset_in_n(bus_if.hard_reset_in_n),
		.quiesce_acknowledge(bus_if.quiesce_acknowledge), .assert_req_i(assert_req_i),
		.stop_req_i(stop_req_i), .extended_mode_o(extended_mode_o), .quiescent_o(quiescent_o));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [2:0] s, input logic [2:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR at %0t: seen %b expected %b", $time, s, e);
		end
	endtask
	task end_of_test();
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task wt(input int k);
		for (int n = 0; n < 20; n++) begin
			@(posedge core_clk_i);
			#1;
			if ((k == 0) ? bus_if.hard_reset_in_n === 1'b1 : quiescent_o === 1'b1) begin
				return;
			end
		end
		num_errors++;
		end_of_test();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		seed = 32'h38dd_3ef5;
		num_errors = 0;
		samples_checked = 0;
		rst_n_i = 1'b0;
		assert_req_i = '0;
		stop_req_i = 1'b0;
		hard_reset_req_i = 1'b1;
		extended_sel_i = 1'b0;
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (int r = 0; r < 6; r++) begin
			@(posedge core_clk_i) hard_reset_req_i <= 1'b1;
			extended_sel_i <= r[0];
			// Model: a low strap at release selects extended precharge.
			mode_q.push_back(r % 2);
			repeat (4) @(posedge core_clk_i);
			hard_reset_req_i <= 1'b0;
			wt(0);
			ext_m = mode_q.pop_front();
			repeat (2) @(posedge core_clk_i);
			// A strap that moves after release must not disturb the latched mode.
			extended_sel_i <= 1'($random(seed));
			#1 chk(3'(extended_mode_o), 3'(ext_m));
			for (int t = 0; t < 4; t++) begin
				ln = {$random(seed)} % NUM_LINES;
				@(posedge core_clk_i) assert_req_i <= 3'b001 << ln;
				@(posedge core_clk_i) #1 chk(bus_if.line_oe, 3'b001 << ln);
				chk(bus_if.line_in, ~(3'b001 << ln));
				repeat ({$random(seed)} % 3) @(posedge core_clk_i);
				@(posedge core_clk_i) assert_req_i <= '0;
				@(posedge core_clk_i) #1 chk(bus_if.line_oe & bus_if.line_out, 3'b001 << ln);
				#12 chk(bus_if.line_oe, 3'(ext_m) << ln);
				@(posedge core_clk_i) #1 chk(bus_if.line_oe, 3'b000);
			end
			@(posedge core_clk_i) stop_req_i <= 1'b1;
			wt(1);
			chk({request_seen_o, bus_if.quiesce_request, bus_if.quiesce_acknowledge}, 3'b111);
			chk(3'(extended_mode_o), 3'(ext_m));
			@(posedge core_clk_i) stop_req_i <= 1'b0;
		end
		end_of_test();
	end
endmodule
`default_nettype wire
